// ==== design/pls_device.sv ====
// Converter end: limit, sequencing and summary status registers behind the management link
// Summary of operation
// - Input above high threshold sets flag, alert.
// - High threshold 500 mV/count, resets 0x20.
// - Host keeps high threshold at most 16 V.
// - Input below low threshold sets flag, alert.
// - Low threshold 250 mV/count, resets 0x1C.
// - Host keeps low threshold above 7 V.
// - Wait turn-on delay after start condition.
// - Turn-on delay 4 ms/count, bits 10:0.
// - Ramp output over soft-start time.
// - Soft-start code 1,2,4,8, else 16 ms.
// - Host reads summary byte by byte read.
// - Latched flags clear only when condition gone.
// - Byte bits 7 and 3 read zero.
// - Bit 6 live: conversion disabled.
// - Bit 5 set on output over-voltage.
// - Bit 4 latches output over-current.
// - Bit 2 live over-temperature.
// - Bit 1 latches bus error.
// - Bit 0: latched input voltage flags, or live other warning.
// - Summary byte is low byte of word.
`timescale 1ns/1ns
`include "pls_consts.svh"

module pls_device #(
   parameter int MS_CYCLES = `PLS_MS_NS / `PLS_CLK_NS
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // Management link
   pls_link_if.dev link,
   // Input voltage measurement, 250 mV per count
   input wire logic [15:0] vin_meas_i,
   input wire logic vin_meas_valid_i,
   // Power stage conditions
   input wire logic start_i,
   input wire logic operation_off_i,
   input wire logic oc_fault_i,
   input wire logic ot_fault_i,
   input wire logic ot_warn_i,
   input wire logic bad_switch_i,
   input wire logic output_overvoltage_flag_fault_i,
   input wire logic vout_uv_fault_i,
   input wire logic other_warn_i,
   // Sequencing
   output logic ramp_o,
   output logic regulating_o,
   output logic [4:0] soft_start_ms_o
);
   import pls_pkg::*;

   localparam int NFLAG = 5;
   localparam int F_HI = 0;
   localparam int F_LO = 1;
   localparam int F_OV = 2;
   localparam int F_OC = 3;
   localparam int F_BUS = 4;

   logic [15:0] vin_high_warn_threshold;
   logic [15:0] vin_low_warn_threshold;
   logic [15:0] turn_on_wait;
   logic [15:0] soft_start_time;
   logic [1:0] clk_s;
   logic [1:0] sel_s;
   logic [1:0] mosi_s;
   logic clk_prev;
   logic sel_prev;
   logic [5:0] bit_cnt;
   logic [24:0] in_sr;
   logic [15:0] out_sr;
   logic hdr_rd;
   logic [7:0] hdr_cmd;
   logic vin_hi_live;
   logic vin_lo_live;
   logic [NFLAG-1:0] flags;
   logic [NFLAG-1:0] cause;
   logic miso;
   logic alert_n;
   pls_seq_t seq;
   logic [15:0] ms_cnt;
   logic [15:0] ms_left;
   logic ms_tick;
   logic link_rise;
   logic link_fall;
   logic frame_end;
   logic wr_evt;
   logic clr_evt;
   logic rd_ok;
   logic err_evt;
   logic fault_in;
   logic [7:0] sum_byte;
   logic [15:0] sum_word;
   logic [7:0] next_cmd;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic cmd_writable(input logic [7:0] c);
      return c == `PLS_CMD_VIN_HI || c == `PLS_CMD_VIN_LO || c == `PLS_CMD_WAIT || c == `PLS_CMD_SOFT;
   endfunction : cmd_writable

   function automatic logic [4:0] soft_ms(input logic [15:0] code);
      if (code[2]) begin
         return 5'h10;
      end
      return 5'(5'h01 << code[1:0]);
   endfunction : soft_ms

   ////////////////////////////////////////////////////////////////////////////
   // Link pins are asynchronous to this clock
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         clk_s <= 2'h0;
         sel_s <= 2'h3;
         mosi_s <= 2'h0;
         clk_prev <= 1'b0;
         sel_prev <= 1'b1;
      end else begin
         clk_s <= {clk_s[0], link.link_clk};
         sel_s <= {sel_s[0], link.link_sel_n};
         mosi_s <= {mosi_s[0], link.link_mosi};
         clk_prev <= clk_s[1];
         sel_prev <= sel_s[1];
      end
   end

   assign link_rise = clk_s[1] & ~clk_prev & ~sel_s[1];
   assign link_fall = ~clk_s[1] & clk_prev & ~sel_s[1];
   assign frame_end = sel_s[1] & ~sel_prev;
   assign next_cmd = {in_sr[6:0], mosi_s[1]};

   ////////////////////////////////////////////////////////////////////////////
   // Frame: read flag, 8-bit command, then 0, 8 or 16 data bits, MSB first
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || sel_s[1]) begin
         bit_cnt <= 6'h00;
      end else if (link_rise && bit_cnt != 6'h3F) begin
         bit_cnt <= bit_cnt + 6'h01;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         in_sr <= 25'h0;
         hdr_rd <= 1'b0;
         hdr_cmd <= 8'h00;
      end else if (link_rise) begin
         in_sr <= {in_sr[23:0], mosi_s[1]};
         if (bit_cnt == `PLS_BITS_HDR - 6'h01) begin
            hdr_rd <= in_sr[7];
            hdr_cmd <= next_cmd;
         end
      end
   end

   assign sum_byte = {1'b0, fault_in || seq == SEQ_IDLE, flags[F_OV], flags[F_OC], 1'b0,
      ot_warn_i | ot_fault_i, flags[F_BUS], flags[F_HI] | flags[F_LO] | other_warn_i};
   assign sum_word = {1'b0, flags[F_OC], flags[F_HI] | flags[F_LO], 5'h00, sum_byte};

   // Read data is fixed once the header is in, so a frame sees one snapshot
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         out_sr <= 16'h0000;
         miso <= 1'b0;
      end else if (sel_s[1]) begin
         miso <= 1'b0;
      end else if (link_rise && bit_cnt == `PLS_BITS_HDR - 6'h01) begin
         unique case (next_cmd)
            `PLS_CMD_VIN_HI: out_sr <= vin_high_warn_threshold;
            `PLS_CMD_VIN_LO: out_sr <= vin_low_warn_threshold;
            `PLS_CMD_WAIT: out_sr <= turn_on_wait;
            `PLS_CMD_SOFT: out_sr <= soft_start_time;
            `PLS_CMD_SUM_BYTE: out_sr <= {sum_byte, 8'h00};
            `PLS_CMD_SUM_WORD: out_sr <= sum_word;
            default: out_sr <= 16'h0000;
         endcase
      end else if (link_fall && bit_cnt >= `PLS_BITS_HDR) begin
         miso <= out_sr[15];
         out_sr <= {out_sr[14:0], 1'b0};
      end
   end

   assign wr_evt = frame_end && !hdr_rd && bit_cnt == `PLS_BITS_WORD && cmd_writable(hdr_cmd);
   assign clr_evt = frame_end && !hdr_rd && bit_cnt == `PLS_BITS_HDR && hdr_cmd == `PLS_CMD_CLEAR;
   assign rd_ok = frame_end && hdr_rd && ((bit_cnt == `PLS_BITS_BYTE && hdr_cmd == `PLS_CMD_SUM_BYTE) ||
      (bit_cnt == `PLS_BITS_WORD && (cmd_writable(hdr_cmd) || hdr_cmd == `PLS_CMD_SUM_WORD)));
   // Any other completed frame counts as a communication error
   assign err_evt = frame_end && bit_cnt != 6'h00 && !wr_evt && !clr_evt && !rd_ok;

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         vin_high_warn_threshold <= `PLS_RST_VIN_HI;
         vin_low_warn_threshold <= `PLS_RST_VIN_LO;
         turn_on_wait <= `PLS_RST_WAIT;
         soft_start_time <= `PLS_RST_SOFT;
      end else if (wr_evt) begin
         unique case (hdr_cmd)
            `PLS_CMD_VIN_HI: vin_high_warn_threshold <= in_sr[15:0] & `PLS_MASK_THR;
            `PLS_CMD_VIN_LO: vin_low_warn_threshold <= in_sr[15:0] & `PLS_MASK_THR;
            `PLS_CMD_WAIT: turn_on_wait <= in_sr[15:0] & `PLS_MASK_WAIT;
            `PLS_CMD_SOFT: soft_start_time <= in_sr[15:0] & `PLS_MASK_SOFT;
            default: soft_start_time <= soft_start_time;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // High threshold counts 500 mV, measurement counts 250 mV
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         vin_hi_live <= 1'b0;
         vin_lo_live <= 1'b0;
      end else if (vin_meas_valid_i) begin
         vin_hi_live <= {1'b0, vin_meas_i} > {vin_high_warn_threshold, 1'b0};
         vin_lo_live <= vin_meas_i < vin_low_warn_threshold;
      end
   end

   assign cause[F_HI] = vin_hi_live;
   assign cause[F_LO] = vin_lo_live;
   assign cause[F_OV] = output_overvoltage_flag_fault_i;
   assign cause[F_OC] = oc_fault_i;
   assign cause[F_BUS] = err_evt;

   // A clear leaves a flag set while its cause persists; set wins over clear
   generate
      for (genvar i = 0; i < NFLAG; i++) begin : g_flag
         always_ff @(posedge sys_clk_i) begin
            if (sys_rst_i) begin
               flags[i] <= 1'b0;
            end else begin
               flags[i] <= cause[i] | (flags[i] & ~clr_evt);
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         alert_n <= 1'b1;
      end else begin
         alert_n <= ~|flags;
      end
   end

   assign link.link_miso = miso;
   assign link.alert_out_n = alert_n;

   ////////////////////////////////////////////////////////////////////////////
   assign fault_in = oc_fault_i | ot_fault_i | bad_switch_i | output_overvoltage_flag_fault_i | vout_uv_fault_i | operation_off_i;
   assign ms_tick = ms_cnt == 16'(MS_CYCLES - 1);

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         seq <= SEQ_IDLE;
         ms_cnt <= 16'h0000;
         ms_left <= 16'h0000;
      end else if (fault_in || !start_i) begin
         seq <= SEQ_IDLE;
         ms_cnt <= 16'h0000;
      end else begin
         ms_cnt <= ms_tick ? 16'h0000 : ms_cnt + 16'h0001;
         unique case (seq)
            SEQ_IDLE: begin
               seq <= SEQ_DELAY;
               ms_cnt <= 16'h0000;
               ms_left <= 16'(turn_on_wait * `PLS_WAIT_MS_PER_LSB);
            end
            SEQ_DELAY: begin
               if (ms_left == 16'h0000) begin
                  seq <= SEQ_RISE;
                  ms_cnt <= 16'h0000;
                  ms_left <= {11'h000, soft_ms(soft_start_time)};
               end else if (ms_tick) begin
                  ms_left <= ms_left - 16'h0001;
               end
            end
            SEQ_RISE: begin
               if (ms_left == 16'h0000) begin
                  seq <= SEQ_ON;
               end else if (ms_tick) begin
                  ms_left <= ms_left - 16'h0001;
               end
            end
            SEQ_ON: seq <= SEQ_ON;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         soft_start_ms_o <= 5'h04;
      end else begin
         soft_start_ms_o <= soft_ms(soft_start_time);
      end
   end

   assign ramp_o = seq[2];
   assign regulating_o = seq[3];

endmodule : pls_device

// ==== design/pls_consts.svh ====
// Command codes, reset values, field positions and timing counts for the converter management link
`ifndef PLS_CONSTS_SVH
`define PLS_CONSTS_SVH

// Device command codes
`define PLS_CMD_CLEAR 8'h03
`define PLS_CMD_VIN_HI 8'h57
`define PLS_CMD_VIN_LO 8'h58
`define PLS_CMD_WAIT 8'h60
`define PLS_CMD_SOFT 8'h61
`define PLS_CMD_SUM_BYTE 8'h78
`define PLS_CMD_SUM_WORD 8'h79

// Device reset values and writable masks
`define PLS_RST_VIN_HI 16'h0020
`define PLS_RST_VIN_LO 16'h001C
`define PLS_RST_WAIT 16'h0000
`define PLS_RST_SOFT 16'h0002
`define PLS_MASK_THR 16'h0FFF
`define PLS_MASK_WAIT 16'h07FF
`define PLS_MASK_SOFT 16'h0007
`define PLS_WAIT_MS_PER_LSB 16'h0004

// Summary flag positions
`define PLS_SB_OFF 6
`define PLS_SB_OUTPUT_OVERVOLTAGE_FLAG 5
`define PLS_SB_OC 4
`define PLS_SB_OT 2
`define PLS_SB_BUS 1
`define PLS_SB_OTHER 0
`define PLS_SW_IOUT 14
`define PLS_SW_VIN 13

// Timing
`define PLS_CLK_NS 40
`define PLS_MS_NS 1000000
`define PLS_HALF_LINK 4'h8

// Frame lengths in link bits
`define PLS_BITS_HDR 6'h09
`define PLS_BITS_BYTE 6'h11
`define PLS_BITS_WORD 6'h19

// Controller register offsets and fields
`define PLS_OFS_CTRL 12'h000
`define PLS_OFS_WDATA 12'h004
`define PLS_OFS_RDATA 12'h008
`define PLS_OFS_STAT 12'h00C
`define PLS_CTRL_READ 8
`define PLS_CTRL_LEN_LSB 9
`define PLS_ST_BUSY 0
`define PLS_ST_DONE 1
`define PLS_ST_ALERT 2

`endif

// ==== design/pls_pkg.sv ====
// Types for the two ends of the converter management link: sequencer states for the converter, frame lengths for the controller
package pls_pkg;

   typedef enum logic [3:0] {
      SEQ_IDLE = 4'b0001,
      SEQ_DELAY = 4'b0010,
      SEQ_RISE = 4'b0100,
      SEQ_ON = 4'b1000
   } pls_seq_t;

   typedef enum logic [1:0] {
      LEN_CMD = 2'h0,
      LEN_BYTE = 2'h1,
      LEN_WORD = 2'h2
   } pls_len_t;

endpackage : pls_pkg

// ==== design/pls_link_if.sv ====
// Serial management link between controller and converter
`timescale 1ns/1ns
interface pls_link_if;
   logic link_clk;
   logic link_sel_n;
   logic link_mosi;
   logic link_miso;
   logic alert_out_n;

   modport ctrl (
      output link_clk,
      output link_sel_n,
      output link_mosi,
      input link_miso,
      input alert_out_n
   );

   modport dev (
      input link_clk,
      input link_sel_n,
      input link_mosi,
      output link_miso,
      output alert_out_n
   );
endinterface : pls_link_if

// ==== design/pls_ctrl.sv ====
// Controller end: APB command registers driving the management link
`timescale 1ns/1ns
`include "pls_consts.svh"

module pls_ctrl (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // APB slave
   input wire logic [11:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Management link
   pls_link_if.ctrl link
);
   import pls_pkg::*;

   logic busy;
   logic done;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic [3:0] div;
   logic [5:0] bit_idx;
   logic [5:0] nbits;
   logic [24:0] tx_sr;
   logic [15:0] rx_sr;
   logic clk_q;
   logic sel_n_q;
   logic mosi_q;
   logic [1:0] miso_s;
   logic [1:0] alert_s;
   logic setup;
   logic wr_acc;
   logic start;
   pls_len_t len;

   ////////////////////////////////////////////////////////////////////////////
   // No wait state: pready rises in the first access cycle
   assign setup = psel_i & ~penable_i;
   assign wr_acc = psel_i & penable_i & pready_o & pwrite_i;
   assign start = wr_acc && paddr_i == `PLS_OFS_CTRL && !busy;
   assign len = pls_len_t'(pwdata_i[`PLS_CTRL_LEN_LSB +: 2]);

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
      end else begin
         pready_o <= setup;
         pslverr_o <= setup && paddr_i != `PLS_OFS_CTRL && paddr_i != `PLS_OFS_WDATA &&
            paddr_i != `PLS_OFS_RDATA && paddr_i != `PLS_OFS_STAT;
         if (setup && !pwrite_i) begin
            unique case (paddr_i)
               `PLS_OFS_WDATA: prdata_o <= {16'h0000, wdata};
               `PLS_OFS_RDATA: prdata_o <= {16'h0000, rdata};
               `PLS_OFS_STAT: prdata_o <= {29'h0, alert_s[1], done, busy};
               default: prdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         wdata <= 16'h0000;
      end else if (wr_acc && paddr_i == `PLS_OFS_WDATA) begin
         wdata <= pwdata_i[15:0];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         miso_s <= 2'h0;
         alert_s <= 2'h0;
      end else begin
         miso_s <= {miso_s[0], link.link_miso};
         alert_s <= {alert_s[0], ~link.alert_out_n};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Link clock is this clock divided by twice the half period; bits change on its fall
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         busy <= 1'b0;
         done <= 1'b0;
         div <= 4'h0;
         bit_idx <= 6'h00;
         nbits <= 6'h00;
         tx_sr <= 25'h0;
         rx_sr <= 16'h0000;
         rdata <= 16'h0000;
         clk_q <= 1'b0;
         sel_n_q <= 1'b1;
         mosi_q <= 1'b0;
      end else if (start) begin
         busy <= 1'b1;
         done <= 1'b0;
         div <= 4'h0;
         bit_idx <= 6'h00;
         nbits <= len == LEN_WORD ? `PLS_BITS_WORD : len == LEN_BYTE ? `PLS_BITS_BYTE : `PLS_BITS_HDR;
         tx_sr <= {pwdata_i[`PLS_CTRL_READ], pwdata_i[7:0], pwdata_i[`PLS_CTRL_READ] ? 16'h0000 : wdata};
         rx_sr <= 16'h0000;
         sel_n_q <= 1'b0;
         mosi_q <= pwdata_i[`PLS_CTRL_READ];
      end else if (busy) begin
         div <= div + 4'h1;
         if (div == `PLS_HALF_LINK - 4'h1) begin
            clk_q <= 1'b1;
            if (bit_idx >= `PLS_BITS_HDR) begin
               rx_sr <= {rx_sr[14:0], miso_s[1]};
            end
         end else if (div == 4'hF) begin
            clk_q <= 1'b0;
            if (bit_idx == nbits - 6'h01) begin
               busy <= 1'b0;
               done <= 1'b1;
               sel_n_q <= 1'b1;
               mosi_q <= 1'b0;
               rdata <= nbits == `PLS_BITS_BYTE ? {8'h00, rx_sr[7:0]} : rx_sr;
            end else begin
               bit_idx <= bit_idx + 6'h01;
               tx_sr <= {tx_sr[23:0], 1'b0};
               mosi_q <= tx_sr[23];
            end
         end
      end
   end

   assign link.link_clk = clk_q;
   assign link.link_sel_n = sel_n_q;
   assign link.link_mosi = mosi_q;

endmodule : pls_ctrl

// ==== test/pls_sva.sv ====
// Checker for the management link timing and the converter sequencing outputs
`timescale 1ns/1ns
module pls_sva #(
   parameter int MS_CYCLES = 10
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // Link
   input wire logic link_clk,
   input wire logic link_sel_n,
   input wire logic alert_out_n,
   // Converter
   input wire logic start_i,
   input wire logic oc_fault_i,
   input wire logic operation_off_i,
   input wire logic ramp_o,
   input wire logic regulating_o,
   input wire logic [4:0] soft_start_ms_o
);
   logic [15:0] ramp_cnt;
   logic [7:0] since_sel;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   always_ff @(posedge sys_clk_i) begin
      ramp_cnt <= ramp_o ? ramp_cnt + 16'h0001 : 16'h0000;
   end
   // Saturates, so an alert that frees itself long after any frame still fails
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) since_sel <= 8'hFF;
      else if (!link_sel_n) since_sel <= 8'h00;
      else if (since_sel != 8'hFF) since_sel <= since_sel + 8'h01;
   end
   sequence half_low_s; !link_clk [*8]; endsequence
   sequence half_high_s; link_clk [*8]; endsequence
   sequence ramp_done_s; ramp_o ##1 (!ramp_o && regulating_o); endsequence
   ////////////////////////////////////////////////////////////////////////
   reset_state_a: assert property ($fell(sys_rst_i) |-> link_sel_n && !link_clk && alert_out_n && !ramp_o)
      else $error("outputs wrong after reset release");
   link_idle_a: assert property (link_sel_n |-> !link_clk) else $error("link clock moves outside a frame");
   frame_start_a: assert property ($fell(link_sel_n) |-> half_low_s ##1 link_clk) else $error("frame start wrong");
   clk_half_a: assert property ($rose(link_clk) |-> half_high_s ##1 !link_clk) else $error("link clock high wrong");
   seq_excl_a: assert property (!(ramp_o && regulating_o)) else $error("ramp and regulation together");
   seq_stop_a: assert property ((!start_i || oc_fault_i || operation_off_i) |=> !ramp_o && !regulating_o)
      else $error("conversion not stopped");
   ramp_first_a: assert property ($rose(regulating_o) |-> $past(ramp_o)) else $error("regulation without ramp");
   start_first_a: assert property ($rose(ramp_o) |-> $past(start_i)) else $error("ramp without start");
   ramp_len_a: assert property (ramp_done_s |-> int'($past(ramp_cnt)) + 3 >= soft_start_ms_o * MS_CYCLES
      && int'($past(ramp_cnt)) <= soft_start_ms_o * MS_CYCLES + 1) else $error("ramp length wrong");
   soft_code_a: assert property ($onehot(soft_start_ms_o)) else $error("soft start time not a power of two");
   alert_hold_a: assert property ($rose(alert_out_n) |-> since_sel <= 8'h0C) else $error("alert freed by itself");
endmodule : pls_sva

// ==== test/testbench.sv ====
// Self-checking bench: controller and converter joined across the management link
`timescale 1ns/1ns
`include "pls_consts.svh"
module testbench;
   import pls_pkg::*;
   localparam int MS = 10;
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [11:0] paddr_i = 12'h000;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [31:0] pwdata_i = 32'h0;
   logic [31:0] prdata_o;
   logic pready_o;
   logic pslverr_o;
   logic [15:0] vin_meas_i = 16'h0030;
   logic vin_meas_valid_i = 1'b0;
   logic start_i = 1'b0;
   // 0 oc, 1 output_overvoltage_flag, 2 ot warn, 3 ot fault, 4 bad switch, 5 vout uv, 6 operation off, 7 other warn
   logic [7:0] cond = 8'h00;
   logic ramp_o;
   logic regulating_o;
   logic [4:0] soft_start_ms_o;
   logic chk_on = 1'b0;
   logic [31:0] exp_q[$];
   int mismatches = 0;
   int cmp_count = 0;
   int seed = 46;
   int n;
   logic ocf = 1'b0;
   logic ovf = 1'b0;
   logic busf = 1'b0;
   logic vinf = 1'b0;
   logic run = 1'b0;
   logic [31:0] r;
   logic perr;
   logic [15:0] v;
   logic [7:0] cmds [4] = '{`PLS_CMD_VIN_HI, `PLS_CMD_VIN_LO, `PLS_CMD_WAIT, `PLS_CMD_SOFT};
   logic [15:0] rsts [4] = '{`PLS_RST_VIN_HI, `PLS_RST_VIN_LO, `PLS_RST_WAIT, `PLS_RST_SOFT};
   logic [15:0] msks [4] = '{`PLS_MASK_THR, `PLS_MASK_THR, `PLS_MASK_WAIT, `PLS_MASK_SOFT};
   logic [7:0] bad [3] = '{8'h55, `PLS_CMD_SUM_BYTE, `PLS_CMD_VIN_HI};
   logic [15:0] waits [3] = '{16'h0000, 16'h0002, 16'h0100};
   pls_link_if link();
   pls_ctrl pls_ctrl_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .paddr_i(paddr_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .link(link));
   pls_device #(.MS_CYCLES(MS)) pls_device_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .link(link),
      .vin_meas_i(vin_meas_i), .vin_meas_valid_i(vin_meas_valid_i), .start_i(start_i), .operation_off_i(cond[6]),
      .oc_fault_i(cond[0]), .ot_fault_i(cond[3]), .ot_warn_i(cond[2]), .bad_switch_i(cond[4]),
      .output_overvoltage_flag_fault_i(cond[1]), .vout_uv_fault_i(cond[5]), .other_warn_i(cond[7]), .ramp_o(ramp_o),
      .regulating_o(regulating_o), .soft_start_ms_o(soft_start_ms_o));
   pls_sva #(.MS_CYCLES(MS)) pls_sva_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .link_clk(link.link_clk),
      .link_sel_n(link.link_sel_n), .alert_out_n(link.alert_out_n), .start_i(start_i), .oc_fault_i(cond[0]),
      .operation_off_i(cond[6]), .ramp_o(ramp_o), .regulating_o(regulating_o), .soft_start_ms_o(soft_start_ms_o));
   always #(`PLS_CLK_NS / 2) sys_clk_i = ~sys_clk_i;
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] sw();
      logic [7:0] b;
      b = {1'b0, |{cond[6:3], cond[1:0]} | !run, ovf, ocf, 1'b0, cond[2] | cond[3], busf, vinf | cond[7]};
      return {1'b0, ocf, vinf, 5'h00, b};
   endfunction : sw
   task automatic check(input logic [31:0] seen, input logic [31:0] expv);
      cmp_count++;
      if (seen !== expv) begin
         mismatches++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask : check
   // Ends with an idle edge so the next call never assigns psel in the same step
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic c);
      paddr_i <= a;
      pwrite_i <= w;
      pwdata_i <= d;
      psel_i <= 1'b1;
      chk_on <= c;
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge sys_clk_i);
      end while (pready_o !== 1'b1);
      r = prdata_o;
      perr = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      chk_on <= 1'b0;
      @(posedge sys_clk_i);
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      apb(a, 1'b0, 32'h0, 1'b1);
   endtask : rd
   task automatic frame(input logic rd_b, input pls_len_t len, input logic [7:0] cmd, input logic [15:0] d);
      apb(`PLS_OFS_WDATA, 1'b1, {16'h0000, d}, 1'b0);
      apb(`PLS_OFS_CTRL, 1'b1, {21'h000000, len, rd_b, cmd}, 1'b0);
      do begin
         apb(`PLS_OFS_STAT, 1'b0, 32'h0, 1'b0);
      end while (r[`PLS_ST_BUSY] !== 1'b0);
      repeat (8) @(posedge sys_clk_i);
   endtask : frame
   task automatic status();
      frame(1'b1, LEN_WORD, `PLS_CMD_SUM_WORD, 16'h0000);
      rd(`PLS_OFS_RDATA, {16'h0000, sw()});
      frame(1'b1, LEN_BYTE, `PLS_CMD_SUM_BYTE, 16'h0000);
      rd(`PLS_OFS_RDATA, {16'h0000, sw() & 16'h00FF});
      rd(`PLS_OFS_STAT, {29'h0, ocf | ovf | busf | vinf, 2'b10});
   endtask : status
   task automatic clear();
      frame(1'b0, LEN_CMD, `PLS_CMD_CLEAR, 16'h0000);
      ocf = cond[0];
      ovf = cond[1];
      busf = 1'b0;
      vinf = 1'b0;
   endtask : clear
   task automatic meas(input logic [15:0] m);
      vin_meas_i <= m;
      vin_meas_valid_i <= 1'b1;
      @(posedge sys_clk_i);
      vin_meas_valid_i <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      vinf = vinf | (m > 16'h0040) | (m < 16'h001D);
      check({31'h0, link.alert_out_n}, {31'h0, !(ocf | ovf | busf | vinf)});
   endtask : meas
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report
   ////////////////////////////////////////////////////////////////////////
   always @(posedge sys_clk_i) begin
      if (chk_on && psel_i && penable_i && pready_o === 1'b1) check(prdata_o, exp_q.pop_front());
   end
   initial begin
      #(`PLS_CLK_NS * 90000);
      mismatches++;
      final_report();
   end
   initial begin
      repeat (6) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge sys_clk_i);
      check({27'h0, soft_start_ms_o}, 32'h4);
      for (int i = 0; i < 4; i++) begin
         frame(1'b1, LEN_WORD, cmds[i], 16'h0000);
         rd(`PLS_OFS_RDATA, {16'h0000, rsts[i]});
      end
      for (int i = 0; i < 4; i++) begin
         v = 16'($random(seed));
         if (i == 0) v = v & 16'hF01F;
         if (i == 1) v = v | 16'h0020;
         frame(1'b0, LEN_WORD, cmds[i], v);
         rd(`PLS_OFS_WDATA, {16'h0000, v});
         check({31'h0, perr}, 32'h0);
         frame(1'b1, LEN_WORD, cmds[i], 16'h0000);
         rd(`PLS_OFS_RDATA, {16'h0000, v & msks[i]});
      end
      // Unmapped offset answers zero with a slave error
      rd(12'h010, 32'h0);
      check({31'h0, perr}, 32'h1);
      for (int i = 0; i < 8; i++) begin
         frame(1'b0, LEN_WORD, `PLS_CMD_SOFT, 16'(i));
         check({27'h0, soft_start_ms_o}, (i < 4) ? (32'h1 << i) : 32'h10);
      end
      frame(1'b0, LEN_WORD, `PLS_CMD_VIN_HI, 16'h0020);
      frame(1'b0, LEN_WORD, `PLS_CMD_VIN_LO, 16'h001D);
      meas(16'h0041);
      status();
      meas(16'h0040);
      clear();
      status();
      meas(16'h001C);
      status();
      meas(16'h001D);
      clear();
      for (int i = 0; i < 8; i++) begin
         cond[i] <= 1'b1;
         @(posedge sys_clk_i);
         ocf = ocf | cond[0];
         ovf = ovf | cond[1];
         status();
         clear();
         status();
         cond[i] <= 1'b0;
         @(posedge sys_clk_i);
         status();
         clear();
      end
      for (int i = 0; i < 3; i++) begin
         frame(i == 2, (i == 2) ? LEN_BYTE : LEN_WORD, bad[i], 16'h1234);
         busf = 1'b1;
         status();
         clear();
         status();
      end
      frame(1'b0, LEN_WORD, `PLS_CMD_SOFT, 16'h0001);
      for (int i = 0; i < 3; i++) begin
         frame(1'b0, LEN_WORD, `PLS_CMD_WAIT, waits[i]);
         start_i <= 1'b1;
         n = 0;
         do begin
            @(posedge sys_clk_i);
            n++;
         end while (ramp_o !== 1'b1 && n < 20000);
         check({31'h0, n + 2 >= waits[i] * `PLS_WAIT_MS_PER_LSB * MS && n <= waits[i] * 40 + 4}, 32'h1);
         n = 0;
         do begin
            @(posedge sys_clk_i);
            n++;
         end while (regulating_o !== 1'b1 && n < 1000);
         check({31'h0, n + 2 >= 2 * MS && n <= 2 * MS + 3}, 32'h1);
         run = 1'b1;
         status();
         cond[6] <= 1'b1;
         @(posedge sys_clk_i);
         run = 1'b0;
         status();
         start_i <= 1'b0;
         cond[6] <= 1'b0;
         @(posedge sys_clk_i);
      end
      final_report();
   end
endmodule : testbench
